// [hw/fpes_map.svh]
// Field positions and timing counts of the flash status engine
`ifndef FPES_MAP_SVH
`define FPES_MAP_SVH
`define FPES_BIT_POLL 7
`define FPES_BIT_TOGGLE 6
`define FPES_BIT_FAIL 5
`define FPES_BIT_EWIN 3
`define FPES_ERASED_BYTE 8'hff
`define FPES_CLK_MHZ 250
`define FPES_WIN_US 100
`define FPES_WIN_PCT 20
`define FPES_WIN_CYC ((`FPES_WIN_US * (100 + `FPES_WIN_PCT) / 100) * `FPES_CLK_MHZ)
`define FPES_PROT_US 100
`define FPES_PROT_CYC (`FPES_PROT_US * `FPES_CLK_MHZ)
`define FPES_PGM_CYC 256
`define FPES_ERS_CYC 1024
`define FPES_PGM_TMO_CYC 512
`endif

// [hw/fpes_pkg.sv]
// Types of the flash status engine
package fpes_pkg;
  // Operation phases
  typedef enum logic [2:0] {
    FPES_IDLE = 3'b000,
    FPES_PGM = 3'b001,
    FPES_EWIN = 3'b010,
    FPES_ERS = 3'b011,
    FPES_PROT = 3'b100,
    FPES_FAIL = 3'b101
  } fpes_state_t;
  // Host bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] data;
  } fpes_req_t;
endpackage : fpes_pkg

// [hw/fpes_timer.sv]
// Down counter giving a one-cycle expiry pulse
`timescale 1ns/1ns
module fpes_timer #(
  parameter int W = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  input wire logic i_stop,
  output logic o_expire
);
  logic [W-1:0] cnt_q; // Remaining cycles, zero means idle
  // Load wins over stop; expire pulses when reaching one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (i_stop) begin
      cnt_q <= '0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign o_expire = (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !i_load && !i_stop;
endmodule : fpes_timer

// [hw/fpes_core.sv]
// Program/erase status engine of an embedded flash array
`timescale 1ns/1ns
`include "fpes_map.svh"
module fpes_core
  import fpes_pkg::*;
#(
  parameter int AW = 12,
  parameter int NSEC = 4,
  parameter int WIN_CYC = `FPES_WIN_CYC,
  parameter int PROT_CYC = `FPES_PROT_CYC,
  parameter int PGM_CYC = `FPES_PGM_CYC,
  parameter int ERS_CYC = `FPES_ERS_CYC,
  parameter int PGM_TMO = `FPES_PGM_TMO_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire fpes_req_t i_req,
  input wire logic [NSEC-1:0] i_main_sector_selects,
  input wire logic [NSEC-1:0] i_sector_protect,
  input wire logic i_cmd_pgm,
  input wire logic i_cmd_sec_erase,
  input wire logic i_cmd_bulk_erase,
  input wire logic i_cmd_reset,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_pgm_stuck,
  input wire logic i_erase_fail,
  output logic [7:0] o_rdata,
  output logic o_mem_wr,
  output logic [AW-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic [NSEC-1:0] o_erase_sectors,
  output logic o_erase_go,
  output logic o_ready_busy_pin
);
  // Whole block state
  typedef struct packed {
    fpes_state_t st;
    logic bulk;
    logic [AW-1:0] addr;
    logic [7:0] data;
    logic [NSEC-1:0] secs;
    logic toggle;
    logic fail;
    logic ewin;
    logic [15:0] opcnt;
    logic [7:0] rdata;
    logic mem_wr;
    logic erase_go;
  } fpes_reg_t;

  logic rst_s1_q; // Reset release synchroniser
  logic rst_n_q;
  fpes_reg_t r_q;
  fpes_reg_t r_d;
  logic win_exp; // Window timer expiry
  logic prot_exp; // Protected-erase hold expiry
  logic win_load;
  logic prot_load;

  // Reset released through two flops so every flop leaves reset together
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Status byte; undefined bits read as zero
  function automatic logic [7:0] status_byte(input logic poll,
      input logic tog, input logic fl, input logic ew);
    logic [7:0] s;
    s = 8'h00;
    s[`FPES_BIT_POLL] = poll;
    s[`FPES_BIT_TOGGLE] = tog;
    s[`FPES_BIT_FAIL] = fl;
    s[`FPES_BIT_EWIN] = ew;
    return s;
  endfunction : status_byte

  // Sectors of a set that protection leaves erasable
  function automatic logic [NSEC-1:0] live_secs(input logic [NSEC-1:0] s,
      input logic [NSEC-1:0] p);
    return s & ~p;
  endfunction : live_secs

  // Accumulation window, restarted by every appended sector erase
  fpes_timer #(.W(20)) u_win (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n_q),
    .i_load(win_load),
    .i_count(20'(WIN_CYC)),
    .i_stop(r_q.st != FPES_EWIN && !win_load),
    .o_expire(win_exp)
  );

  // Hold time for an erase whose sectors are all protected
  fpes_timer #(.W(20)) u_prot (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n_q),
    .i_load(prot_load),
    .i_count(20'(PROT_CYC)),
    .i_stop(1'b0),
    .o_expire(prot_exp)
  );

  logic sel; // Any sector select active
  logic in_target; // Read is at the busy location or sector
  logic busy;
  logic [7:0] stat;
  logic prot_hit; // Program target lies in a protected sector
  logic pgm_op; // Last operation was a byte program, not an erase

  // Next-state logic for the whole engine
  always_comb begin
    r_d = r_q;
    r_d.mem_wr = 1'b0;
    r_d.erase_go = 1'b0;
    win_load = 1'b0;
    prot_load = 1'b0;
    sel = |i_main_sector_selects;
    prot_hit = |(i_main_sector_selects & i_sector_protect);
    busy = (r_q.st != FPES_IDLE) && (r_q.st != FPES_FAIL);
    pgm_op = (r_q.secs == '0) && !r_q.bulk;
    // A failed program keeps answering at its target address
    in_target = (r_q.st == FPES_PGM || (r_q.st == FPES_FAIL && pgm_op))
        ? (i_req.addr == r_q.addr)
        : |(i_main_sector_selects & r_q.secs) || r_q.bulk;
    stat = 8'h00;
    case (r_q.st)
      FPES_IDLE: begin
        if (i_cmd_pgm && i_req.wr) begin
          // Command decoder pulses on the fourth write
          if (!prot_hit) begin
            r_d.st = FPES_PGM;
            r_d.addr = i_req.addr;
            r_d.data = i_req.data;
            r_d.opcnt = '0;
            r_d.fail = 1'b0;
            r_d.secs = '0; // No erase set while a byte programs
            r_d.bulk = 1'b0;
          end
        end else if ((i_cmd_sec_erase || i_cmd_bulk_erase) && i_req.wr) begin
          // Sixth write: erase begins, status now valid
          r_d.bulk = i_cmd_bulk_erase;
          r_d.secs = i_cmd_bulk_erase ? {NSEC{1'b1}}
              : i_main_sector_selects;
          r_d.ewin = 1'b0;
          r_d.opcnt = '0;
          if (i_cmd_bulk_erase) begin
            r_d.st = FPES_ERS;
          end else begin
            r_d.st = FPES_EWIN;
            win_load = 1'b1;
          end
        end
      end
      FPES_PGM: begin
        // No reset branch here: a program cannot be aborted
        r_d.opcnt = r_q.opcnt + 16'h0001;
        if (|(r_q.data & ~i_mem_rdata) && r_q.opcnt == 16'h0001) begin
          r_d.fail = 1'b1;
        end else if (r_q.opcnt >= 16'(PGM_TMO)) begin
          r_d.fail = 1'b1;
        end else if (r_q.opcnt == 16'(PGM_CYC) && !i_pgm_stuck) begin
          // A stuck cell never commits, so the timeout above ends it
          r_d.data = r_q.data & i_mem_rdata;
          r_d.mem_wr = 1'b1;
          r_d.st = FPES_IDLE;
        end
        if (r_d.fail) begin
          r_d.st = FPES_FAIL;
        end
      end
      FPES_EWIN: begin
        if (i_cmd_sec_erase && i_req.wr) begin
          // Appended sector: restart window
          r_d.secs = r_q.secs | i_main_sector_selects;
          win_load = 1'b1;
        end else if (i_cmd_reset && i_req.wr) begin
          r_d.st = FPES_IDLE;
        end else if (win_exp) begin
          r_d.ewin = 1'b1;
          if (live_secs(r_q.secs, i_sector_protect) == '0) begin
            r_d.st = FPES_PROT;
            prot_load = 1'b1;
          end else begin
            r_d.st = FPES_ERS;
            r_d.secs = live_secs(r_q.secs, i_sector_protect);
          end
        end
        // An appended instruction also shows the window closed
        if (i_cmd_sec_erase && i_req.wr) begin
          r_d.ewin = 1'b1;
        end
      end
      FPES_ERS: begin
        r_d.opcnt = r_q.opcnt + 16'h0001;
        if (r_q.opcnt == 16'h0000 && r_q.bulk &&
            live_secs(r_q.secs, i_sector_protect) == '0) begin
          r_d.st = FPES_PROT;
          prot_load = 1'b1;
        end else if (i_erase_fail) begin
          r_d.st = FPES_FAIL;
          r_d.fail = 1'b1;
        end else if (i_cmd_reset && i_req.wr && !r_q.bulk) begin
          r_d.st = FPES_IDLE; // Sector erase may be aborted
        end else if (r_q.opcnt == 16'(ERS_CYC)) begin
          r_d.erase_go = 1'b1;
          r_d.secs = live_secs(r_q.secs, i_sector_protect);
          r_d.st = FPES_IDLE;
        end
      end
      FPES_PROT: begin
        if (prot_exp) begin
          r_d.st = FPES_IDLE;
        end
      end
      FPES_FAIL: begin
        if (i_cmd_reset && i_req.wr) begin
          r_d.fail = 1'b0;
          r_d.st = FPES_IDLE;
        end
      end
      default: begin
        r_d.st = FPES_IDLE;
      end
    endcase
    // Read path: status while not idle and targeted (in PROT, any selected read), else memory byte
    if (r_q.st == FPES_PGM || (r_q.st == FPES_FAIL && pgm_op)) begin
      stat = status_byte(~r_q.data[7], r_q.toggle, r_q.fail,
          1'b0);
    end else if (r_q.st == FPES_PROT) begin
      stat = status_byte(1'b0, 1'b0, 1'b0, r_q.ewin);
    end else begin
      stat = status_byte(1'b0, r_q.toggle, r_q.fail,
          r_q.ewin);
    end
    if (i_req.rd) begin
      if (r_q.st != FPES_IDLE && sel && (in_target ||
          r_q.st == FPES_PROT)) begin
        r_d.rdata = stat;
        if (busy && r_q.st != FPES_PROT) begin
          r_d.toggle = ~r_q.toggle;
        end
      end else begin
        r_d.rdata = i_mem_rdata;
      end
    end
  end

  // Single state register
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_rdata = r_q.rdata;
  assign o_mem_wr = r_q.mem_wr;
  assign o_mem_addr = r_q.addr;
  assign o_mem_wdata = r_q.data;
  assign o_erase_sectors = r_q.secs;
  assign o_erase_go = r_q.erase_go;
  // Low while the embedded algorithm runs
  assign o_ready_busy_pin = !(r_q.st == FPES_PGM || r_q.st == FPES_EWIN
      || r_q.st == FPES_ERS);

  // Poll flag inverts programmed bit 7 while programming
  a_poll_pgm: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_PGM && i_req.rd && sel && i_req.addr == r_q.addr
      |=> o_rdata[7] == ~$past(r_q.data[7]))
    else $error("poll flag not inverted");
  // Toggle inverts between back-to-back targeted reads during erase
  a_toggle_flip: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_ERS && i_req.rd && sel && in_target
      |=> r_q.toggle != $past(r_q.toggle))
    else $error("toggle flag did not invert");
  // Fail stays until reset instruction
  a_fail_hold: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.fail && !(i_cmd_reset && i_req.wr) |=> r_q.fail)
    else $error("fail flag dropped");
  // Busy pin low throughout erase
  a_busy_ers: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_ERS |-> !o_ready_busy_pin)
    else $error("ready during erase");
  // Window flag low on entering window
  a_ewin_low: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_IDLE && r_d.st == FPES_EWIN |=> !r_q.ewin)
    else $error("window flag not cleared");
  // Window flag high once window expires
  a_ewin_set: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      win_exp && r_q.st == FPES_EWIN |=> r_q.ewin)
    else $error("window flag not set");
  // Protected program leaves state idle
  a_prot_pgm: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_IDLE && i_cmd_pgm && i_req.wr && prot_hit
      |=> r_q.st == FPES_IDLE && !o_mem_wr)
    else $error("protected program accepted");
  // Reset ignored while programming
  a_rst_ign: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_PGM && !r_d.fail && r_q.opcnt != 16'(PGM_CYC)
      |=> r_q.st == FPES_PGM)
    else $error("program aborted");
  // Hold after an all-protected erase reads poll and toggle as zero
  a_prot_zero: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_PROT && i_req.rd && sel |=> o_rdata[7:6] == 2'b00)
    else $error("protected erase status not zero");
  // A program that outlives its timeout ends in the fail state
  a_pgm_tmo: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_PGM && r_q.opcnt >= 16'(PGM_TMO)
      |=> r_q.st == FPES_FAIL && r_q.fail)
    else $error("program timeout not flagged");
  // Erase failure raises the fail flag
  a_ers_fail: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      r_q.st == FPES_ERS && r_q.opcnt != 16'h0000 && i_erase_fail
      |=> r_q.st == FPES_FAIL && r_q.fail)
    else $error("erase failure not flagged");
endmodule : fpes_core

// [verification/fpes_flash_model.sv]
// Flash array model that answers the status engine
`timescale 1ns/1ns
module fpes_flash_model (
  input wire logic i_ref_clk,
  input wire logic [11:0] i_addr,
  input wire logic i_mem_wr,
  input wire logic [11:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic [3:0] i_erase_sectors,
  input wire logic i_erase_go,
  output logic [7:0] o_mem_rdata
);
  // Array contents; the top two address bits pick the sector
  logic [7:0] mem [4096];
  // Array starts fully erased
  initial begin
    foreach (mem[k]) begin
      mem[k] = 8'hff;
    end
  end
  // Commit programs; erase whole sectors, never single bytes
  always @(posedge i_ref_clk) begin
    if (i_mem_wr) begin
      mem[i_mem_addr] <= i_mem_wdata;
    end
    if (i_erase_go) begin
      foreach (mem[k]) begin
        if (i_erase_sectors[k[11:10]]) begin
          mem[k] <= 8'hff;
        end
      end
    end
  end
  // Reads are combinational, so the engine sees the live byte
  assign o_mem_rdata = mem[i_addr];
endmodule : fpes_flash_model

// [verification/fpes_core_bench.sv]
// Self-checking bench of the flash status engine
`timescale 1ns/1ns
module fpes_core_bench;
  import fpes_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  fpes_req_t req = '0;
  logic [3:0] sel = 4'h0;
  logic [3:0] prot = 4'h0;
  logic [3:0] cmd = 4'h0; // Program, sector erase, bulk erase, reset
  logic stuck = 1'b0;
  logic efail = 1'b0;
  logic [7:0] rdata, mrd, a, b, mwd;
  logic mwr, ego, rb;
  logic [11:0] maddr;
  logic [3:0] esec;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  localparam logic [3:0] PGM = 4'h8, SEC = 4'h4, BLK = 4'h2, RST = 4'h1;
  always #2 clk = ~clk;
  // Short counts keep the run brief
  fpes_core #(.WIN_CYC(20), .PROT_CYC(20), .PGM_CYC(16), .ERS_CYC(16),
    .PGM_TMO(24)) fpes_core_i (.i_ref_clk(clk), .i_arst_n(arst_n),
    .i_req(req), .i_main_sector_selects(sel), .i_sector_protect(prot),
    .i_cmd_pgm(cmd[3]), .i_cmd_sec_erase(cmd[2]),
    .i_cmd_bulk_erase(cmd[1]), .i_cmd_reset(cmd[0]), .i_mem_rdata(mrd),
    .i_pgm_stuck(stuck), .i_erase_fail(efail), .o_rdata(rdata),
    .o_mem_wr(mwr), .o_mem_addr(maddr), .o_mem_wdata(mwd),
    .o_erase_sectors(esec), .o_erase_go(ego), .o_ready_busy_pin(rb));
  fpes_flash_model fpes_flash_model_i (.i_ref_clk(clk),
    .i_addr(req.addr), .i_mem_wr(mwr), .i_mem_addr(maddr),
    .i_mem_wdata(mwd), .i_erase_sectors(esec), .i_erase_go(ego),
    .o_mem_rdata(mrd));
  // Masked byte compare; only the defined bits are looked at
  task automatic chk8(input logic [7:0] g, e, m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g & m, e & m);
    end
  endtask : chk8
  // Single flag compare
  task automatic chk1(input logic g, e);
    chk8({7'h0, g}, {7'h0, e}, 8'h01);
  endtask : chk1
  // One write cycle carrying a decoded instruction
  task automatic op(input logic [3:0] c, input logic [11:0] ad,
      input logic [7:0] d);
    @(posedge clk) #1;
    req.wr = 1'b1;
    req.addr = ad;
    req.data = d;
    cmd = c;
    @(posedge clk) #1;
    req.wr = 1'b0;
    cmd = 4'h0;
  endtask : op
  // One read cycle; data lands one edge after the strobe
  task automatic rd(input logic [11:0] ad, output logic [7:0] d);
    @(posedge clk) #1;
    req.rd = 1'b1;
    req.addr = ad;
    @(posedge clk) #1;
    req.rd = 1'b0;
    d = rdata;
  endtask : rd
  // Bounded wait on the ready pin instead of a fixed delay
  task automatic wait_ready();
    n = 0;
    while (rb !== 1'b1 && n < 200) begin
      @(posedge clk) #1;
      n++;
    end
    chk1(rb, 1'b1);
  endtask : wait_ready
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // Watchdog: the tests need well under two thousand cycles
  initial begin
    #40000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk1(rb, 1'b1);
    // Program an erased byte; a reset meanwhile must not abort it
    sel = 4'h1;
    op(PGM, 12'h010, 8'h5a);
    rd(12'h010, a);
    chk1(rb, 1'b0);
    rd(12'h010, b);
    chk8(a, 8'h80, 8'ha0);
    chk8(a ^ b, 8'h40, 8'h40);
    op(RST, 12'h010, 8'hf0);
    wait_ready();
    rd(12'h010, a);
    rd(12'h010, b);
    chk8(a, 8'h5a, 8'hff);
    chk8(a ^ b, 8'h00, 8'hff);
    $display("program test done");
    // Program into a protected sector is dropped
    sel = 4'h2;
    prot = 4'h2;
    op(PGM, 12'h400, 8'h00);
    rd(12'h400, a);
    chk1(rb, 1'b1);
    chk8(a, 8'hff, 8'hff);
    $display("protected program test done");
    // Turning a 0 bit back to 1 fails and sticks until reset
    sel = 4'h1;
    prot = 4'h0;
    op(PGM, 12'h010, 8'hff);
    repeat (4) @(posedge clk);
    rd(12'h010, a);
    rd(12'h010, b);
    chk8(a, 8'h20, 8'h20);
    chk8(a ^ b, 8'h00, 8'h60);
    chk1(rb, 1'b1);
    op(RST, 12'h010, 8'hf0);
    repeat (2) @(posedge clk);
    rd(12'h010, a);
    chk8(a, 8'h5a, 8'hff);
    $display("fail flag test done");
    // Sector erase: window flag low, then erasing, then all ones
    sel = 4'h4;
    op(PGM, 12'h800, 8'h00);
    wait_ready();
    op(SEC, 12'h800, 8'h30);
    rd(12'h800, a);
    chk8(a, 8'h00, 8'ha8);
    repeat (21) @(posedge clk);
    rd(12'h800, a);
    rd(12'h800, b);
    chk8(a, 8'h08, 8'ha8);
    chk8(a ^ b, 8'h40, 8'h40);
    wait_ready();
    rd(12'h800, a);
    chk8(a, 8'hff, 8'hff);
    $display("sector erase test done");
    // Erase of only protected sectors: poll bit zero a while, no erase
    sel = 4'h8;
    op(PGM, 12'hc00, 8'h55);
    wait_ready();
    prot = 4'h8;
    op(SEC, 12'hc00, 8'h30);
    n = 0;
    rd(12'hc00, a);
    while (a !== 8'h55 && n < 60) begin
      chk8(a, 8'h00, 8'h80);
      rd(12'hc00, a);
      n++;
    end
    chk8(a, 8'h55, 8'hff);
    chk1(n >= 9, 1'b1);
    $display("protected erase test done");
    // Bulk erase ignores a reset and clears sector 3, checked at 0xc00
    prot = 4'h0;
    sel = 4'h1;
    op(BLK, 12'h555, 8'h10);
    op(RST, 12'h555, 8'hf0);
    wait_ready();
    rd(12'hc00, a);
    chk8(a, 8'hff, 8'hff);
    $display("bulk erase test done");
    // A stuck cell never commits; the byte timeout raises fail
    stuck = 1'b1;
    op(PGM, 12'h011, 8'ha5);
    repeat (30) @(posedge clk);
    rd(12'h011, a);
    chk8(a, 8'h20, 8'ha0);
    chk1(rb, 1'b1);
    stuck = 1'b0;
    op(RST, 12'h011, 8'hf0);
    rd(12'h011, a);
    chk8(a, 8'hff, 8'hff);
    $display("program timeout test done");
    // Erase failure shows anywhere in the erasing sector until reset
    sel = 4'h2;
    op(SEC, 12'h400, 8'h30);
    repeat (24) @(posedge clk);
    #1 efail = 1'b1;
    @(posedge clk) #1;
    efail = 1'b0;
    rd(12'h456, a);
    chk8(a, 8'h28, 8'ha8);
    op(RST, 12'h400, 8'hf0);
    rd(12'h400, a);
    chk8(a, 8'hff, 8'hff);
    $display("erase fail test done");
    summarize();
  end
endmodule : fpes_core_bench
